// File: include/cpcf_pkg.sv
// shared constants and types for the cam control pins and cascade flags
package cpcf_pkg;
    localparam int DQ_W = 32;
    localparam int AC_W = 13;
    localparam int PG_W = 4;
    localparam int RI_W = PG_W + AC_W;
    localparam int INSTR_W = 12;
    localparam int CLK_NS = 10;
    localparam int STROBE_LOW_NS = 40;
    localparam int STROBE_HIGH_NS = 20;
    localparam int RESET_PULSE_NS = 100;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    localparam logic [1:0] HITS_NONE = 2'h0;
    localparam logic [1:0] HITS_ONE = 2'h1;
    localparam logic [1:0] HITS_MULTI = 2'h2;
    localparam logic [RI_W-1:0] RIDX_ALL_ONES = {RI_W{1'b1}};
    localparam logic [RI_W-1:0] RIDX_RESET = {RI_W{1'b1}};
    localparam logic FLAG_RESET = 1'b1;
    localparam logic [DQ_W-1:0] INSTR_MASK = DQ_W'((64'h1 << INSTR_W) - 64'h1);
    typedef enum logic [2:0] {
        CMD_HW_MEM_WR = 3'h0,
        CMD_HW_MEM_RD = 3'h1,
        CMD_HW_CTRL_WR = 3'h2,
        CMD_HW_CTRL_RD = 3'h3,
        CMD_SW_DATA_WR = 3'h4,
        CMD_SW_DATA_RD = 3'h5,
        CMD_SW_INSTR = 3'h6
    } cpcf_cmd_t;
endpackage

// File: include/cpcf_if.sv
// pin-level link between the lookup device and its controller
`timescale 1ns/10ps
interface cpcf_if;
    import cpcf_pkg::*;
    logic strobe_n;
    logic select_a_n;
    logic select_b_n;
    logic write_n;
    logic out_enable_n;
    logic addr_qualifier_n;
    logic [AC_W-1:0] addr_ctrl_bus;
    logic data_half_select;
    logic [DQ_W-1:0] host_data_o;
    logic host_data_oe_n;
    logic [DQ_W-1:0] dev_data_o;
    logic dev_data_oe_n;
    logic host_valid_o;
    logic host_valid_oe_n;
    logic dev_valid_o;
    logic dev_valid_oe_n;
    logic [RI_W-1:0] result_index_o;
    logic result_index_oe_n;
    logic match_chain_in_n;
    logic match_flag_out_n;
    logic full_chain_in_n;
    logic full_flag_out_n;
    logic multi_hit_o;
    logic multi_hit_oe_n;
    logic reset_n;
    logic test_reset_n;
    // resolved wire levels, pulled up when nobody drives
    logic [DQ_W-1:0] data_lines;
    logic entry_valid_n;
    logic [RI_W-1:0] result_index_bus;
    logic multi_hit_n;
    assign data_lines = !host_data_oe_n ? host_data_o : (!dev_data_oe_n ? dev_data_o : {DQ_W{1'b1}});
    assign entry_valid_n = !host_valid_oe_n ? host_valid_o : (!dev_valid_oe_n ? dev_valid_o : 1'b1);
    assign result_index_bus = !result_index_oe_n ? result_index_o : {RI_W{1'b1}};
    assign multi_hit_n = multi_hit_oe_n ? 1'b1 : multi_hit_o;
    modport device (
        input strobe_n, select_a_n, select_b_n, write_n, out_enable_n, addr_qualifier_n,
        input addr_ctrl_bus, data_half_select, data_lines, entry_valid_n,
        input match_chain_in_n, full_chain_in_n, reset_n, test_reset_n,
        output dev_data_o, dev_data_oe_n, dev_valid_o, dev_valid_oe_n,
        output result_index_o, result_index_oe_n, match_flag_out_n, full_flag_out_n,
        output multi_hit_o, multi_hit_oe_n
    );
    modport host (
        output strobe_n, select_a_n, select_b_n, write_n, out_enable_n, addr_qualifier_n,
        output addr_ctrl_bus, data_half_select, host_data_o, host_data_oe_n,
        output host_valid_o, host_valid_oe_n, match_chain_in_n, full_chain_in_n,
        output reset_n, test_reset_n,
        input data_lines, entry_valid_n, result_index_bus, match_flag_out_n,
        input full_flag_out_n, multi_hit_n
    );
endinterface

// File: verilog/cpcf_device.sv
// device end: control pin capture, result bus drive and cascade flags
`timescale 1ns/10ps
// Functional notes
// - either select low means selected
// - selects gate hits and address-move result drive
// - selects, direction, qualifier taken at strobe fall
// - direction low accepts, high drives data
// - decoded command depends on direction too
// - output enable high floats result bus
// - highest priority hit device drives compare results; selected device drives address moves
// - hardware mode: qualifier picks address/control
// - software mode: qualifier picks data/instruction
// - write marks entry valid per validity line
// - read with qualifier low drives entry validity onto line
// - match flag low on hit or chain
// - match flag updates only after compare
// - system chains match flags, top tied high
// - full flag low: all valid, chain low
// - full flag updates only after write
// - system chains full flags, top tied low
// - chain high: two hits pull multi-hit
// - chain low: one hit pulls multi-hit
// - multi-hit open drain, changes after compare
// - low reset pin forces reset state
// - test reset returns test logic reset
// - system mismatch: lowest device drives ones
module cpcf_device
    import cpcf_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    cpcf_if.device bus, // pins toward controller and cascade
    input wire logic sw_control, // high selects software control
    input wire logic [PG_W-1:0] page_addr, // page address of this device
    input wire logic is_lowest, // device is lowest priority in cascade
    output logic cmd_take, // pulse: captured cycle fields valid
    output cpcf_cmd_t cmd_kind_ff, // decoded cycle kind
    output logic [AC_W-1:0] cmd_ctrl_ff, // captured address/control bus
    output logic cmd_half_ff, // captured data half select
    output logic [DQ_W-1:0] cmd_data_ff, // captured write data
    output logic cmd_mark_valid_ff, // write sets entry valid
    output logic cycle_done, // pulse: strobe rose, cycle ended
    input wire logic cycle_is_compare, // current cycle is a compare
    input wire logic cycle_moves_addr, // current cycle changes active address
    input wire logic [1:0] hit_count, // compare hits: none, one, multi
    input wire logic [AC_W-1:0] hit_addr, // highest priority hit index
    input wire logic [AC_W-1:0] access_addr, // accessed memory index
    input wire logic all_entries_valid, // every entry is valid
    input wire logic [DQ_W-1:0] read_data, // data for a read cycle
    input wire logic read_valid, // validity of addressed entry
    output logic test_logic_reset_ff // test port held in reset
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_END = 3'b100
    } cpcf_dev_st_t;

    cpcf_dev_st_t st_ff;
    cpcf_dev_st_t nxt_st;
    logic strobe_q_ff;
    logic fall;
    logic rise;
    logic srst;
    logic sel_ff;
    logic write_n_ff;
    logic qual_n_ff;
    logic [DQ_W-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic mf_ff;
    logic ff_ff;
    logic mm_ff;
    logic [RI_W-1:0] ridx_ff;
    logic ridx_ok_ff;
    logic local_hit;
    logic drive_data;

    // pin reset joins the system reset
    assign srst = rst || !bus.reset_n;

    // strobe edges from the sampled pin
    assign fall = strobe_q_ff && !bus.strobe_n;
    assign rise = !strobe_q_ff && bus.strobe_n;

    always_ff @(posedge clk)
    begin
        if (srst)
            strobe_q_ff <= 1'b1;
        else
            strobe_q_ff <= bus.strobe_n;
    end

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:
            begin
                if (fall)
                    nxt_st = ST_LOW;
            end
            ST_LOW:
            begin
                if (rise)
                    nxt_st = ST_END;
            end
            ST_END:
            begin
                nxt_st = fall ? ST_LOW : ST_IDLE;
            end
            default:
            begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_ff <= ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    // capture control pins at strobe fall
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sel_ff <= 1'b0;
            write_n_ff <= 1'b1;
            qual_n_ff <= 1'b0;
            cmd_ctrl_ff <= '0;
            cmd_half_ff <= 1'b0;
        end
        else if (fall)
        begin
            sel_ff <= !bus.select_a_n || !bus.select_b_n;
            write_n_ff <= bus.write_n;
            qual_n_ff <= bus.addr_qualifier_n;
            cmd_ctrl_ff <= bus.addr_ctrl_bus;
            cmd_half_ff <= bus.data_half_select;
        end
    end

    // write data accepted only with direction low
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd_data_ff <= '0;
            cmd_mark_valid_ff <= 1'b0;
        end
        else if (fall && !bus.write_n)
        begin
            // instruction uses the twelve low lines
            if (sw_control && bus.addr_qualifier_n)
                cmd_data_ff <= bus.data_lines & INSTR_MASK;
            else
                cmd_data_ff <= bus.data_lines;
            // validity line low marks entry valid
            cmd_mark_valid_ff <= !bus.entry_valid_n;
        end
    end

    // decode kind from mode, qualifier and direction
    always_ff @(posedge clk)
    begin
        if (srst)
            cmd_kind_ff <= CMD_HW_MEM_RD;
        else if (fall)
        begin
            if (sw_control)
                cmd_kind_ff <= bus.addr_qualifier_n ? CMD_SW_INSTR
                    : (bus.write_n ? CMD_SW_DATA_RD : CMD_SW_DATA_WR);
            else if (bus.addr_qualifier_n)
                cmd_kind_ff <= bus.write_n ? CMD_HW_CTRL_RD : CMD_HW_CTRL_WR;
            else
                cmd_kind_ff <= bus.write_n ? CMD_HW_MEM_RD : CMD_HW_MEM_WR;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cmd_take <= 1'b0;
        else
            cmd_take <= fall && (!bus.select_a_n || !bus.select_b_n);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cycle_done <= 1'b0;
        else
            cycle_done <= rise && st_ff == ST_LOW;
    end

    // read data and validity sampled every clock while strobe is low
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b1;
        end
        else if (st_ff == ST_LOW)
        begin
            rd_data_ff <= read_data;
            rd_valid_ff <= !read_valid;
        end
    end

    // drive data lines for selected read-direction cycles
    assign drive_data = st_ff == ST_LOW && sel_ff && write_n_ff && !bus.strobe_n;
    assign bus.dev_data_o = rd_data_ff;
    assign bus.dev_data_oe_n = !drive_data;
    assign bus.dev_valid_o = rd_valid_ff;
    assign bus.dev_valid_oe_n = !(drive_data && !qual_n_ff);

    // deselected devices clear earlier hits on a compare
    assign local_hit = sel_ff && hit_count != HITS_NONE;

    // match flag moves only at compare end
    always_ff @(posedge clk)
    begin
        if (srst)
            mf_ff <= FLAG_RESET;
        else if (rise && st_ff == ST_LOW && cycle_is_compare)
            // low on local hit or chain low
            mf_ff <= !(local_hit || !bus.match_chain_in_n);
    end

    // full flag moves only at write end
    always_ff @(posedge clk)
    begin
        if (srst)
            ff_ff <= FLAG_RESET;
        else if (rise && st_ff == ST_LOW && !write_n_ff)
            // low only when all valid and chain low
            ff_ff <= !(all_entries_valid && !bus.full_chain_in_n);
    end

    // multi-hit changes only at compare end
    always_ff @(posedge clk)
    begin
        if (srst)
            mm_ff <= 1'b0;
        else if (rise && st_ff == ST_LOW && cycle_is_compare)
        begin
            if (bus.match_chain_in_n)
                mm_ff <= sel_ff && hit_count == HITS_MULTI;
            else
                mm_ff <= local_hit;
        end
    end

    // result index launched at strobe rise, held while strobe low
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ridx_ff <= RIDX_RESET;
            ridx_ok_ff <= 1'b0;
        end
        else if (rise && st_ff == ST_LOW)
        begin
            if (cycle_is_compare)
            begin
                // only the highest priority responder, or the lowest device on a miss, drives
                ridx_ok_ff <= (local_hit && bus.match_chain_in_n)
                    || (!local_hit && bus.match_chain_in_n && is_lowest);
                ridx_ff <= local_hit ? {page_addr, hit_addr} : RIDX_ALL_ONES;
            end
            else if (sel_ff && cycle_moves_addr)
            begin
                ridx_ok_ff <= 1'b1;
                ridx_ff <= {page_addr, access_addr};
            end
        end
    end

    // drive depends on output enable and on priority or a selected address move
    // output enable high floats the bus
    assign bus.result_index_o = ridx_ff;
    assign bus.result_index_oe_n = bus.out_enable_n || !ridx_ok_ff;

    assign bus.match_flag_out_n = mf_ff;
    assign bus.full_flag_out_n = ff_ff;
    // open drain: only ever pulls low
    assign bus.multi_hit_o = 1'b0;
    assign bus.multi_hit_oe_n = !mm_ff;

    // test reset held while its pin is low
    always_ff @(posedge clk)
    begin
        if (rst)
            test_logic_reset_ff <= 1'b1;
        else
            test_logic_reset_ff <= !bus.test_reset_n;
    end
endmodule

// File: verilog/cpcf_host.sv
// controller end: runs strobe cycles and ties the top cascade inputs
`timescale 1ns/10ps
module cpcf_host
    import cpcf_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    cpcf_if.host bus, // pins toward the device
    input wire logic req_valid, // request a strobe cycle
    output logic req_ready, // host idle, request can be taken
    input wire logic req_write, // high for write direction
    input wire logic req_qual, // drive qualifier high
    input wire logic [1:0] req_select, // select lines to assert
    input wire logic [AC_W-1:0] req_ctrl, // address/control value
    input wire logic req_half, // data half select
    input wire logic [DQ_W-1:0] req_data, // write data
    input wire logic req_mark_valid, // write marks entry valid
    input wire logic out_enable, // enable device result bus
    input wire logic test_reset, // hold device test logic reset
    output logic rsp_valid, // pulse: read data captured
    output logic [DQ_W-1:0] rsp_data_ff, // captured read data
    output logic rsp_entry_valid_ff // captured entry validity
);
    typedef enum logic [3:0] {
        HS_RESET = 4'b0001,
        HS_IDLE = 4'b0010,
        HS_LOW = 4'b0100,
        HS_HIGH = 4'b1000
    } cpcf_host_st_t;

    cpcf_host_st_t st_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic write_ff;

    assign req_ready = st_ff == HS_IDLE;
    // top device chain input tied high
    assign bus.match_chain_in_n = 1'b1;
    // top device chain input tied low
    assign bus.full_chain_in_n = 1'b0;
    assign bus.out_enable_n = !out_enable;
    assign bus.test_reset_n = !test_reset;
    // reset pin low for the minimum pulse
    assign bus.reset_n = st_ff != HS_RESET;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= HS_RESET;
            cnt_ff <= '0;
        end
        else
        begin
            case (st_ff)
                HS_RESET:
                begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (cnt_ff == CNT_W'(RESET_CYC - 1))
                        st_ff <= HS_IDLE;
                end
                HS_IDLE:
                begin
                    cnt_ff <= '0;
                    if (req_valid)
                        st_ff <= HS_LOW;
                end
                HS_LOW:
                begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (cnt_ff == CNT_W'(STROBE_LOW_CYC - 1))
                    begin
                        cnt_ff <= '0;
                        st_ff <= HS_HIGH;
                    end
                end
                HS_HIGH:
                begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (cnt_ff == CNT_W'(STROBE_HIGH_CYC - 1))
                        st_ff <= HS_IDLE;
                end
                default:
                begin
                    st_ff <= HS_RESET;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // pins set up when the request is taken, held through the cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus.strobe_n <= 1'b1;
            bus.select_a_n <= 1'b1;
            bus.select_b_n <= 1'b1;
            bus.write_n <= 1'b1;
            bus.addr_qualifier_n <= 1'b0;
            bus.addr_ctrl_bus <= '0;
            bus.data_half_select <= 1'b0;
            bus.host_data_o <= '0;
            bus.host_valid_o <= 1'b1;
            write_ff <= 1'b0;
        end
        else if (req_ready && req_valid)
        begin
            bus.strobe_n <= 1'b0;
            bus.select_a_n <= !req_select[0];
            bus.select_b_n <= !req_select[1];
            bus.write_n <= !req_write;
            bus.addr_qualifier_n <= req_qual;
            bus.addr_ctrl_bus <= req_ctrl;
            bus.data_half_select <= req_half;
            bus.host_data_o <= req_data;
            bus.host_valid_o <= !req_mark_valid;
            write_ff <= req_write;
        end
        else if (st_ff == HS_LOW && cnt_ff == CNT_W'(STROBE_LOW_CYC - 1))
        begin
            bus.strobe_n <= 1'b1;
            write_ff <= 1'b0;
        end
    end

    // host drives data and validity only for writes
    assign bus.host_data_oe_n = !write_ff;
    assign bus.host_valid_oe_n = !write_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_data_ff <= '0;
            rsp_entry_valid_ff <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (st_ff == HS_LOW && cnt_ff == CNT_W'(STROBE_LOW_CYC - 1) && bus.write_n)
            begin
                rsp_valid <= 1'b1;
                rsp_data_ff <= bus.data_lines;
                rsp_entry_valid_ff <= !bus.entry_valid_n;
            end
        end
    end
endmodule

// File: verif/cpcf_checker.sv
// assertions on the pins between controller and device
`timescale 1ns/10ps
module cpcf_checker
    import cpcf_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic strobe_n, // strobe
    input wire logic write_n, // direction
    input wire logic select_a_n, // select a
    input wire logic select_b_n, // select b
    input wire logic out_enable_n, // result enable
    input wire logic reset_n, // device reset
    input wire logic dev_data_oe_n, // data drive
    input wire logic dev_valid_oe_n, // valid drive
    input wire logic [RI_W-1:0] result_index_o, // result value
    input wire logic result_index_oe_n, // result drive
    input wire logic match_flag_out_n, // match flag
    input wire logic full_flag_out_n, // full flag
    input wire logic multi_hit_oe_n // multi-hit pull
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_res_float;
        out_enable_n |-> result_index_oe_n;
    endproperty
    a_res_float: assert property (p_res_float) else $error("result bus driven while disabled");
    property p_data_dir;
        !dev_data_oe_n |-> write_n && !(select_a_n && select_b_n);
    endproperty
    a_data_dir: assert property (p_data_dir) else $error("data driven without read select");
    property p_valid_dir;
        !dev_valid_oe_n |-> write_n && !strobe_n;
    endproperty
    a_valid_dir: assert property (p_valid_dir) else $error("validity driven outside read");
    property p_match_hold;
        $changed(match_flag_out_n) && $past(reset_n) |-> $past(strobe_n) && !$past(strobe_n, 2);
    endproperty
    a_match_hold: assert property (p_match_hold) else $error("match flag moved mid cycle");
    property p_mm_hold;
        $changed(multi_hit_oe_n) && $past(reset_n) |-> $past(strobe_n) && !$past(strobe_n, 2);
    endproperty
    a_mm_hold: assert property (p_mm_hold) else $error("multi-hit moved mid cycle");
    property p_full_hold;
        $changed(full_flag_out_n) && $past(reset_n) |-> $past(strobe_n) && !$past(strobe_n, 2) && !$past(write_n, 2);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag moved outside write end");
    property p_ridx_hold;
        $changed(result_index_o) && $past(reset_n) |-> $past(strobe_n) && !$past(strobe_n, 2);
    endproperty
    a_ridx_hold: assert property (p_ridx_hold) else $error("result moved while latched");
    property p_reset_state;
        !reset_n |=> match_flag_out_n && full_flag_out_n && multi_hit_oe_n && result_index_oe_n && dev_data_oe_n;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs active in reset");
    property p_strobe_shape;
        $fell(strobe_n) |-> !strobe_n [*4] ##1 strobe_n [*2];
    endproperty
    a_strobe_shape: assert property (p_strobe_shape) else $error("strobe width wrong");
    c_match: cover property (!match_flag_out_n);
    c_multi: cover property (!multi_hit_oe_n);
    c_result: cover property (!result_index_oe_n && !full_flag_out_n);
endmodule

// File: verif/tb_top.sv
// random and corner bench for the controller and device ends
`timescale 1ns/10ps
module tb_top;
    import cpcf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b0, req_qual = 1'b0, req_half = 1'b0, req_mark_valid = 1'b0;
    logic out_enable = 1'b0, test_reset = 1'b0, sw_control = 1'b0, is_lowest = 1'b0, read_valid = 1'b0;
    logic cycle_is_compare = 1'b0, cycle_moves_addr = 1'b0, all_entries_valid = 1'b0;
    logic [1:0] req_select = 2'h0, hit_count = 2'h0;
    logic [AC_W-1:0] req_ctrl = 13'h0, hit_addr = 13'h0, access_addr = 13'h0, cmd_ctrl_ff;
    logic [PG_W-1:0] page_addr = 4'h5;
    logic [DQ_W-1:0] req_data = 32'h0, read_data = 32'h0, rsp_data_ff, cmd_data_ff;
    logic req_ready, rsp_valid, rsp_entry_valid_ff, cmd_take, cmd_half_ff, cmd_mark_valid_ff;
    logic cycle_done, test_logic_reset_ff;
    cpcf_cmd_t cmd_kind_ff;
    logic exp_match = 1'b1, exp_mm = 1'b1, exp_full = 1'b1, exp_drive = 1'b0;
    logic [RI_W-1:0] exp_ridx = RIDX_RESET;
    logic [31:0] rnd = 32'h62; // seed 98
    int fail_count = 0, num_checks = 0, cycles = 0;
    cpcf_if lnk();
    cpcf_host i_cpcf_host (.clk, .rst, .bus(lnk), .req_valid, .req_ready, .req_write, .req_qual, .req_select,
        .req_ctrl, .req_half, .req_data, .req_mark_valid, .out_enable, .test_reset, .rsp_valid, .rsp_data_ff,
        .rsp_entry_valid_ff);
    cpcf_device i_cpcf_device (.clk, .rst, .bus(lnk), .sw_control, .page_addr, .is_lowest, .cmd_take,
        .cmd_kind_ff, .cmd_ctrl_ff, .cmd_half_ff, .cmd_data_ff, .cmd_mark_valid_ff, .cycle_done,
        .cycle_is_compare, .cycle_moves_addr, .hit_count, .hit_addr, .access_addr, .all_entries_valid,
        .read_data, .read_valid, .test_logic_reset_ff);
    cpcf_checker i_cpcf_checker (.clk, .rst, .strobe_n(lnk.strobe_n), .write_n(lnk.write_n),
        .select_a_n(lnk.select_a_n), .select_b_n(lnk.select_b_n), .out_enable_n(lnk.out_enable_n),
        .reset_n(lnk.reset_n), .dev_data_oe_n(lnk.dev_data_oe_n), .dev_valid_oe_n(lnk.dev_valid_oe_n),
        .result_index_o(lnk.result_index_o), .result_index_oe_n(lnk.result_index_oe_n),
        .match_flag_out_n(lnk.match_flag_out_n), .full_flag_out_n(lnk.full_flag_out_n),
        .multi_hit_oe_n(lnk.multi_hit_oe_n));
    always #(CLK_NS / 2) clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic cpcf_cmd_t exp_kind(input logic sw, input logic q, input logic w);
        if (sw)
            return q ? CMD_SW_INSTR : (w ? CMD_SW_DATA_WR : CMD_SW_DATA_RD);
        return q ? (w ? CMD_HW_CTRL_WR : CMD_HW_CTRL_RD) : (w ? CMD_HW_MEM_WR : CMD_HW_MEM_RD);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic pick();
        rnd = lfsr(rnd);
        req_data = rnd;
        rnd = lfsr(rnd);
        read_data = rnd;
        rnd = lfsr(rnd);
        {req_write, req_qual, req_select, req_half, req_mark_valid, out_enable, sw_control} = rnd[7:0];
        {is_lowest, cycle_is_compare, cycle_moves_addr, read_valid} = rnd[11:8];
        hit_count = rnd[13:12] % 2'h3;
        req_ctrl = rnd[26:14];
        rnd = lfsr(rnd);
        hit_addr = rnd[12:0];
        access_addr = rnd[25:13];
    endtask
    // one strobe cycle from request to flag update
    task automatic run_cycle();
        int n;
        logic took, sel, hit, rv;
        n = 0;
        took = 1'b0;
        rv = 1'b0;
        sel = req_select != 2'h0;
        if (req_write && sel)
            all_entries_valid = rnd[27];
        while (!req_ready && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (!cycle_done && n < 20)
        begin
            @(negedge clk);
            took |= cmd_take;
            rv |= rsp_valid;
            n++;
        end
        check(cycle_done, 1'b1, "cycle end");
        check(took, sel, "selection");
        check(rv, !req_write, "read strobe");
        if (sel)
        begin
            check(cmd_kind_ff, exp_kind(sw_control, req_qual, req_write), "kind");
            check({cmd_half_ff, cmd_ctrl_ff}, {req_half, req_ctrl}, "ctrl capture");
        end
        if (sel && req_write)
        begin
            check(cmd_data_ff, (sw_control && req_qual) ? req_data & INSTR_MASK : req_data, "wdata");
            check(cmd_mark_valid_ff, req_mark_valid, "mark");
        end
        if (!req_write)
            check(rsp_data_ff, sel ? read_data : 32'hFFFFFFFF, "rdata");
        if (!req_write && sel && !req_qual)
            check(rsp_entry_valid_ff, read_valid, "validity read");
        hit = sel && hit_count != HITS_NONE;
        if (cycle_is_compare)
        begin
            exp_match = !hit;
            exp_mm = !(sel && hit_count == HITS_MULTI);
            exp_drive = hit || is_lowest;
            exp_ridx = hit ? {page_addr, hit_addr} : RIDX_ALL_ONES;
        end
        else if (sel && cycle_moves_addr)
        begin
            exp_drive = 1'b1;
            exp_ridx = {page_addr, access_addr};
        end
        if (sel && req_write)
            exp_full = !all_entries_valid;
        check(lnk.match_flag_out_n, exp_match, "match flag");
        check(lnk.multi_hit_n, exp_mm, "multi-hit");
        check(lnk.full_flag_out_n, exp_full, "full flag");
        check(lnk.result_index_oe_n, !(out_enable && exp_drive), "result drive");
        if (out_enable && exp_drive)
            check(lnk.result_index_bus, exp_ridx, "result value");
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check({lnk.match_flag_out_n, lnk.full_flag_out_n, lnk.multi_hit_n, lnk.result_index_oe_n}, 4'hF, "reset");
        $display("test reset done");
        for (int i = 0; i < 64; i++)
        begin
            pick();
            {cycle_is_compare, req_select, req_write, req_qual, sw_control} = 6'(i);
            run_cycle();
        end
        $display("test corners done");
        repeat (200)
        begin
            pick();
            run_cycle();
        end
        $display("test random done");
        test_reset = 1'b1;
        repeat (2) @(negedge clk);
        check(test_logic_reset_ff, 1'b1, "test logic held");
        test_reset = 1'b0;
        repeat (2) @(negedge clk);
        check(test_logic_reset_ff, 1'b0, "test logic free");
        $display("test test-port done");
        report_and_stop();
    end
endmodule
